// ===== ttc_pkg.sv
package ttc_pkg;
	localparam logic [3:0]  ADR_CTRL_A   = 4'h0;
	localparam logic [3:0]  ADR_CTRL_B   = 4'h1;
	localparam logic [3:0]  ADR_CTRL_C   = 4'h2;
	localparam logic [3:0]  ADR_CNT_LO   = 4'h4;
	localparam logic [3:0]  ADR_CNT_HI   = 4'h5;
	localparam logic [3:0]  ADR_CAP_LO   = 4'h6;
	localparam logic [3:0]  ADR_CAP_HI   = 4'h7;
	localparam logic [3:0]  ADR_CMPA_LO  = 4'h8;
	localparam logic [3:0]  ADR_CMPA_HI  = 4'h9;
	localparam logic [3:0]  ADR_CMPB_LO  = 4'hA;
	localparam logic [3:0]  ADR_CMPB_HI  = 4'hB;
	localparam logic [3:0]  ADR_IRQ_EN   = 4'hC;
	localparam logic [3:0]  ADR_IRQ_FLG  = 4'hD;
	localparam int          COMA_LSB     = 6;
	localparam int          COMB_LSB     = 4;
	localparam int          FILTER_BIT   = 7;
	localparam int          EDGE_BIT     = 6;
	localparam int          WGM_HI_LSB   = 3;
	localparam logic [7:0]  CTRL_B_WMASK = 8'hDF;
	localparam int          FORCE_A_BIT  = 7;
	localparam int          FORCE_B_BIT  = 6;
	localparam int          CAP_BIT      = 5;
	localparam int          CMPB_BIT     = 2;
	localparam int          CMPA_BIT     = 1;
	localparam int          OVF_BIT      = 0;
	localparam logic [7:0]  IRQ_MASK     = 8'h27;
	localparam logic [7:0]  RST_BYTE     = 8'h00;
	localparam logic [15:0] RST_WORD     = 16'h0000;
	localparam logic [3:0]  FILTER_ONES  = 4'hF;
	localparam logic [2:0]  SRC_STOP     = 3'h0;
	localparam logic [2:0]  SRC_DIV1     = 3'h1;
	localparam logic [2:0]  SRC_DIV8     = 3'h2;
	localparam logic [2:0]  SRC_DIV64    = 3'h3;
	localparam logic [2:0]  SRC_DIV256   = 3'h4;
	localparam logic [2:0]  SRC_DIV1024  = 3'h5;
	localparam logic [2:0]  SRC_EXT_FALL = 3'h6;
	localparam logic [2:0]  SRC_EXT_RISE = 3'h7;
	localparam int          PRE_W        = 10;
	localparam int          SH_8         = 3;
	localparam int          SH_64        = 6;
	localparam int          SH_256       = 8;
	localparam logic [15:0] TOP_MAX      = 16'hFFFF;
	localparam logic [15:0] TOP_8        = 16'h00FF;
	localparam logic [15:0] TOP_9        = 16'h01FF;
	localparam logic [15:0] TOP_10       = 16'h03FF;
	localparam logic [1:0]  COM_OFF      = 2'h0;
	localparam logic [1:0]  COM_TOG      = 2'h1;
	typedef enum logic [1:0] {CLS_PLAIN, CLS_FAST, CLS_PHASE} ttc_class_t;
	typedef enum logic [2:0] {SEL_MAX, SEL_8, SEL_9, SEL_10, SEL_CMPA,
		SEL_CAP} ttc_top_t;
	function automatic ttc_class_t mode_class(input logic [3:0] w);
		if (!w[3])
			return (w[1:0] == 2'h0) ? CLS_PLAIN : (w[2] ? CLS_FAST : CLS_PHASE);
		if (!w[2])
			return CLS_PHASE;
		return w[1] ? CLS_FAST : CLS_PLAIN;
	endfunction
	function automatic ttc_top_t top_sel(input logic [3:0] w);
		if (w[3])
			return (w[2:0] == 3'h5) ? SEL_MAX : (w[0] ? SEL_CMPA : SEL_CAP);
		unique case (w[1:0])
			2'h0: return w[2] ? SEL_CMPA : SEL_MAX;
			2'h1: return SEL_8;
			2'h2: return SEL_9;
			2'h3: return SEL_10;
		endcase
	endfunction
endpackage

// ===== ttc_pin_sync.sv
`timescale 1ns/1ps
module ttc_pin_sync (
	input  wire logic clk_sys_in,
	input  wire logic reset_in,
	input  wire logic raw_in,
	output logic      level_out
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} ttc_sync_t;
	ttc_sync_t r;
	ttc_sync_t n;
	always_comb begin
		n    = r;
		n.s1 = raw_in;
		n.s2 = r.s1;
		n.s3 = r.s2;
		// level moves only once the second and third stages agree
		if (r.s2 == r.s3)
			n.lvl = r.s3;
	end
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in)
			r <= '0;
		else
			r <= n;
	end
	assign level_out = r.lvl;
endmodule

// ===== ttc_out_chan.sv
`timescale 1ns/1ps
module ttc_out_chan (
	input  wire logic                clk_sys_in,
	input  wire logic                reset_in,
	input  wire logic [1:0]          mode_in,
	input  wire ttc_pkg::ttc_class_t class_in,
	input  wire logic                toggle_ok_in,
	input  wire logic                match_in,
	input  wire logic                force_in,
	input  wire logic                top_in,
	input  wire logic                down_in,
	output logic                     pin_out,
	output logic                     en_out
);
	typedef struct packed {
		logic pin;
		logic en;
	} ttc_chan_t;
	ttc_chan_t r;
	ttc_chan_t n;
	logic      lvl;
	logic      hit;
	logic      pwm;
	always_comb begin
		n    = r;
		hit  = match_in || force_in;
		pwm  = class_in != ttc_pkg::CLS_PLAIN;
		n.en = mode_in != ttc_pkg::COM_OFF &&
			!(mode_in == ttc_pkg::COM_TOG && pwm && !toggle_ok_in);
		lvl  = mode_in[0];
		if (class_in == ttc_pkg::CLS_PHASE && down_in)
			lvl = !mode_in[0];
		if (mode_in == ttc_pkg::COM_TOG) begin
			if (hit && n.en)
				n.pin = !r.pin;
		end else if (mode_in[1]) begin
			if (hit)
				n.pin = lvl;
			else if (class_in == ttc_pkg::CLS_FAST && top_in)
				n.pin = !lvl;
		end
	end
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in)
			r <= '0;
		else
			r <= n;
	end
	assign pin_out = r.pin;
	assign en_out  = r.en;
endmodule

// ===== ttc_timer16.sv
// Functional notes
// - filter on: filtered capture level changes after four equal samples
// - edge select zero captures falling edges, one captures rising edges
// - capture copies counter into capture register and sets capture flag
// - capture function is off while capture register is the top value
// - clock source: stop, undivided, divide by 8, 64, 256, 1024
// - source 110 counts falling, 111 rising edges of external count pin
// - external pin counts even when it is driven as an output
// - force bit in non-pwm modes applies a match to the channel output
// - forced match sets no flag, raises no irq, never clears counter
// - force bits and the other six control c bits read as zero
// - all 16-bit registers pass through one shared high-byte latch
// - counter write suppresses all compare matches on next timer clock
// - each compare register is checked against counter every timer clock
// - capture source is the pin or optionally the comparator output
// - irq requested only when enable, global flag and status flag set
// - bits 7, 6, 4, 3 of enable and flag registers read zero
// - in capture-top modes capture flag sets when counter reaches top
// - compare flag sets in the timer clock after counter equals compare
// - flags clear on vector execution or on writing one
// - overflow flag sets on overflow in normal and clear modes
// - overflow at max, at top in fast pwm, at bottom in phase modes
`timescale 1ns/1ps
module ttc_timer16 (
	input  wire logic       clk_sys_in,
	input  wire logic       reset_in,
	input  wire logic [3:0] io_addr_in,
	input  wire logic [7:0] io_wdata_in,
	input  wire logic       io_we_in,
	input  wire logic       io_re_in,
	output logic      [7:0] io_rdata_out,
	input  wire logic       global_irq_en_in,
	input  wire logic [3:0] vec_ack_in,
	input  wire logic       capture_input_pin_in,
	input  wire logic       comparator_in,
	input  wire logic       capture_from_comparator_in,
	input  wire logic       external_count_pin_in,
	output logic            capture_irq_out,
	output logic            compare_b_irq_out,
	output logic            compare_a_irq_out,
	output logic            overflow_irq_out,
	output logic            compare_output_pin_a_out,
	output logic            compare_output_en_a_out,
	output logic            compare_output_pin_b_out,
	output logic            compare_output_en_b_out
);
	typedef struct packed {
		logic [7:0]  ctrl_a;
		logic [7:0]  ctrl_b;
		logic [7:0]  temp;
		logic [15:0] cnt;
		logic [15:0] cap;
		logic [15:0] cmp_a;
		logic [15:0] cmp_b;
		logic [7:0]  irq_en;
		logic [7:0]  flg;
		logic [7:0]  rdata;
		logic [9:0]  pre;
		logic [3:0]  filt;
		logic        filt_out;
		logic        cap_d;
		logic        ext_d;
		logic        down;
		logic        blk;
		logic [3:0]  irq;
	} ttc_core_t;

	ttc_core_t           r;
	ttc_core_t           n;
	logic [3:0]          wgm;
	ttc_pkg::ttc_class_t cls;
	ttc_pkg::ttc_top_t   sel;
	logic [15:0]         top;
	logic                cap_top;
	logic                at_top;
	logic                at_bot;
	logic                tick;
	logic                src;
	logic                cap_ev;
	logic                top_ev;
	logic                ma;
	logic                mb;
	logic                ov_ev;
	logic                dn;
	logic                frc_a;
	logic                frc_b;
	logic                pin_lvl;
	logic                cmp_lvl;
	logic                ext_lvl;

	ttc_pin_sync u_sync_cap (
		.clk_sys_in (clk_sys_in),
		.reset_in   (reset_in),
		.raw_in     (capture_input_pin_in),
		.level_out  (pin_lvl)
	);
	ttc_pin_sync u_sync_cmp (
		.clk_sys_in (clk_sys_in),
		.reset_in   (reset_in),
		.raw_in     (comparator_in),
		.level_out  (cmp_lvl)
	);
	// pin level is sampled whatever the pin direction
	ttc_pin_sync u_sync_ext (
		.clk_sys_in (clk_sys_in),
		.reset_in   (reset_in),
		.raw_in     (external_count_pin_in),
		.level_out  (ext_lvl)
	);

	always_comb begin
		n       = r;
		wgm     = {r.ctrl_b[ttc_pkg::WGM_HI_LSB +: 2], r.ctrl_a[1:0]};
		cls     = ttc_pkg::mode_class(wgm);
		sel     = ttc_pkg::top_sel(wgm);
		unique case (sel)
			ttc_pkg::SEL_MAX:  top = ttc_pkg::TOP_MAX;
			ttc_pkg::SEL_8:    top = ttc_pkg::TOP_8;
			ttc_pkg::SEL_9:    top = ttc_pkg::TOP_9;
			ttc_pkg::SEL_10:   top = ttc_pkg::TOP_10;
			ttc_pkg::SEL_CMPA: top = r.cmp_a;
			default:           top = r.cap;
		endcase
		cap_top = sel == ttc_pkg::SEL_CAP;
		at_top  = r.cnt == top;
		at_bot  = r.cnt == ttc_pkg::RST_WORD;
		n.pre   = r.pre + 10'h001;
		n.ext_d = ext_lvl;
		// timer clock select
		unique case (r.ctrl_b[2:0])
			ttc_pkg::SRC_STOP:     tick = 1'b0;
			ttc_pkg::SRC_DIV1:     tick = 1'b1;
			ttc_pkg::SRC_DIV8:     tick = &r.pre[ttc_pkg::SH_8-1:0];
			ttc_pkg::SRC_DIV64:    tick = &r.pre[ttc_pkg::SH_64-1:0];
			ttc_pkg::SRC_DIV256:   tick = &r.pre[ttc_pkg::SH_256-1:0];
			ttc_pkg::SRC_DIV1024:  tick = &r.pre;
			ttc_pkg::SRC_EXT_FALL: tick = r.ext_d && !ext_lvl;
			ttc_pkg::SRC_EXT_RISE: tick = !r.ext_d && ext_lvl;
		endcase
		// capture source, filter and edge detect
		src    = capture_from_comparator_in ? cmp_lvl : pin_lvl;
		n.filt = {r.filt[2:0], src};
		if (!r.ctrl_b[ttc_pkg::FILTER_BIT])
			n.filt_out = src;
		else if (r.filt == ttc_pkg::FILTER_ONES)
			n.filt_out = 1'b1;
		else if (r.filt == ~ttc_pkg::FILTER_ONES)
			n.filt_out = 1'b0;
		n.cap_d = r.filt_out;
		cap_ev  = r.filt_out != r.cap_d && !cap_top &&
			r.filt_out == r.ctrl_b[ttc_pkg::EDGE_BIT];
		top_ev  = tick && cap_top && at_top;
		// compare every timer clock unless a counter write blocks it
		ma      = tick && !r.blk && r.cnt == r.cmp_a;
		mb      = tick && !r.blk && r.cnt == r.cmp_b;
		unique case (cls)
			ttc_pkg::CLS_PLAIN: ov_ev = tick && r.cnt == ttc_pkg::TOP_MAX;
			ttc_pkg::CLS_FAST:  ov_ev = tick && at_top;
			default:            ov_ev = tick && at_bot;
		endcase
		// counter
		dn = r.down;
		if (tick) begin
			n.blk = 1'b0;
			if (cls == ttc_pkg::CLS_PHASE) begin
				if (at_top)
					dn = 1'b1;
				else if (at_bot)
					dn = 1'b0;
				n.down = dn;
				n.cnt  = dn ? r.cnt - 16'h0001 : r.cnt + 16'h0001;
			end else begin
				n.down = 1'b0;
				n.cnt  = at_top ? ttc_pkg::RST_WORD : r.cnt + 16'h0001;
			end
		end
		// register writes
		frc_a = 1'b0;
		frc_b = 1'b0;
		if (io_we_in) begin
			unique case (io_addr_in)
				ttc_pkg::ADR_CTRL_A: n.ctrl_a = io_wdata_in;
				ttc_pkg::ADR_CTRL_B: n.ctrl_b = io_wdata_in &
					ttc_pkg::CTRL_B_WMASK;
				ttc_pkg::ADR_CTRL_C: begin
					// strobes only act in non-pwm modes
					if (cls == ttc_pkg::CLS_PLAIN) begin
						frc_a = io_wdata_in[ttc_pkg::FORCE_A_BIT];
						frc_b = io_wdata_in[ttc_pkg::FORCE_B_BIT];
					end
				end
				ttc_pkg::ADR_CNT_HI,
				ttc_pkg::ADR_CAP_HI,
				ttc_pkg::ADR_CMPA_HI,
				ttc_pkg::ADR_CMPB_HI: n.temp = io_wdata_in;
				ttc_pkg::ADR_CNT_LO: begin
					n.cnt = {r.temp, io_wdata_in};
					n.blk = 1'b1;
				end
				ttc_pkg::ADR_CAP_LO:  n.cap   = {r.temp, io_wdata_in};
				ttc_pkg::ADR_CMPA_LO: n.cmp_a = {r.temp, io_wdata_in};
				ttc_pkg::ADR_CMPB_LO: n.cmp_b = {r.temp, io_wdata_in};
				ttc_pkg::ADR_IRQ_EN:  n.irq_en = io_wdata_in &
					ttc_pkg::IRQ_MASK;
				ttc_pkg::ADR_IRQ_FLG: n.flg = r.flg &
					~(io_wdata_in & ttc_pkg::IRQ_MASK);
				default: ;
			endcase
		end
		// register reads, low byte latches the high byte
		if (io_re_in) begin
			unique case (io_addr_in)
				ttc_pkg::ADR_CTRL_A: n.rdata = r.ctrl_a;
				ttc_pkg::ADR_CTRL_B: n.rdata = r.ctrl_b;
				ttc_pkg::ADR_CNT_LO: begin
					n.rdata = r.cnt[7:0];
					n.temp  = r.cnt[15:8];
				end
				ttc_pkg::ADR_CAP_LO: begin
					n.rdata = r.cap[7:0];
					n.temp  = r.cap[15:8];
				end
				ttc_pkg::ADR_CMPA_LO: begin
					n.rdata = r.cmp_a[7:0];
					n.temp  = r.cmp_a[15:8];
				end
				ttc_pkg::ADR_CMPB_LO: begin
					n.rdata = r.cmp_b[7:0];
					n.temp  = r.cmp_b[15:8];
				end
				ttc_pkg::ADR_CNT_HI,
				ttc_pkg::ADR_CAP_HI,
				ttc_pkg::ADR_CMPA_HI,
				ttc_pkg::ADR_CMPB_HI: n.rdata = r.temp;
				ttc_pkg::ADR_IRQ_EN:  n.rdata = r.irq_en;
				ttc_pkg::ADR_IRQ_FLG: n.rdata = r.flg;
				default:              n.rdata = ttc_pkg::RST_BYTE;
			endcase
		end
		// vector acknowledge clears, then hardware sets win
		if (vec_ack_in[3])
			n.flg[ttc_pkg::CAP_BIT] = 1'b0;
		if (vec_ack_in[2])
			n.flg[ttc_pkg::CMPB_BIT] = 1'b0;
		if (vec_ack_in[1])
			n.flg[ttc_pkg::CMPA_BIT] = 1'b0;
		if (vec_ack_in[0])
			n.flg[ttc_pkg::OVF_BIT] = 1'b0;
		if (cap_ev) begin
			n.cap = r.cnt;
			n.flg[ttc_pkg::CAP_BIT] = 1'b1;
		end
		if (top_ev)
			n.flg[ttc_pkg::CAP_BIT] = 1'b1;
		// forced strobes never reach the flags or the counter
		if (ma)
			n.flg[ttc_pkg::CMPA_BIT] = 1'b1;
		if (mb)
			n.flg[ttc_pkg::CMPB_BIT] = 1'b1;
		if (ov_ev)
			n.flg[ttc_pkg::OVF_BIT] = 1'b1;
		n.irq = {4{global_irq_en_in}} & {
			r.flg[ttc_pkg::CAP_BIT] & r.irq_en[ttc_pkg::CAP_BIT],
			r.flg[ttc_pkg::CMPB_BIT] & r.irq_en[ttc_pkg::CMPB_BIT],
			r.flg[ttc_pkg::CMPA_BIT] & r.irq_en[ttc_pkg::CMPA_BIT],
			r.flg[ttc_pkg::OVF_BIT] & r.irq_en[ttc_pkg::OVF_BIT]};
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in)
			r <= '0;
		else
			r <= n;
	end

	ttc_out_chan u_chan_a (
		.clk_sys_in   (clk_sys_in),
		.reset_in     (reset_in),
		.mode_in      (r.ctrl_a[ttc_pkg::COMA_LSB +: 2]),
		.class_in     (cls),
		.toggle_ok_in (wgm[3]),
		.match_in     (ma && !(cls == ttc_pkg::CLS_FAST && r.cmp_a == top)),
		.force_in     (frc_a),
		.top_in       (tick && at_top),
		.down_in      (r.down),
		.pin_out      (compare_output_pin_a_out),
		.en_out       (compare_output_en_a_out)
	);
	ttc_out_chan u_chan_b (
		.clk_sys_in   (clk_sys_in),
		.reset_in     (reset_in),
		.mode_in      (r.ctrl_a[ttc_pkg::COMB_LSB +: 2]),
		.class_in     (cls),
		.toggle_ok_in (1'b0),
		.match_in     (mb && !(cls == ttc_pkg::CLS_FAST && r.cmp_b == top)),
		.force_in     (frc_b),
		.top_in       (tick && at_top),
		.down_in      (r.down),
		.pin_out      (compare_output_pin_b_out),
		.en_out       (compare_output_en_b_out)
	);

	assign io_rdata_out      = r.rdata;
	assign capture_irq_out   = r.irq[3];
	assign compare_b_irq_out = r.irq[2];
	assign compare_a_irq_out = r.irq[1];
	assign overflow_irq_out  = r.irq[0];

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);

	sequence s_hi_wr;
		io_we_in && io_addr_in == ttc_pkg::ADR_CMPA_HI;
	endsequence
	sequence s_lo_wr;
		io_we_in && io_addr_in == ttc_pkg::ADR_CMPA_LO;
	endsequence
	sequence s_flg_clr;
		io_we_in && io_addr_in == ttc_pkg::ADR_IRQ_FLG &&
			io_wdata_in[ttc_pkg::OVF_BIT] && !ov_ev;
	endsequence

	chk_filter_hold: assert property (
		r.ctrl_b[ttc_pkg::FILTER_BIT] && n.filt_out != r.filt_out |->
		(r.filt == ttc_pkg::FILTER_ONES || r.filt == ~ttc_pkg::FILTER_ONES))
		else $error("filtered capture changed without four equal samples");
	chk_capture_copy: assert property (
		cap_ev |=> r.cap == $past(r.cnt) && r.flg[ttc_pkg::CAP_BIT])
		else $error("capture did not copy counter or set flag");
	chk_capture_off: assert property (
		cap_top && !(io_we_in && io_addr_in == ttc_pkg::ADR_CAP_LO) |=>
		r.cap == $past(r.cap))
		else $error("capture taken while capture register is top");
	chk_stopped_count: assert property (
		r.ctrl_b[2:0] == ttc_pkg::SRC_STOP && !io_we_in |=>
		r.cnt == $past(r.cnt))
		else $error("counter moved while clock source stopped");
	chk_force_no_flag: assert property (
		frc_a && !ma |=> !$rose(r.flg[ttc_pkg::CMPA_BIT]))
		else $error("forced compare set the compare flag");
	chk_ctrl_c_zero: assert property (
		io_re_in && io_addr_in == ttc_pkg::ADR_CTRL_C |=> io_rdata_out == 8'h00)
		else $error("control c did not read zero");
	chk_shared_latch: assert property (
		s_hi_wr ##2 s_lo_wr |=> r.cmp_a == {$past(io_wdata_in, 3),
		$past(io_wdata_in)})
		else $error("16-bit write not assembled from latch");
	chk_write_blocks: assert property (
		io_we_in && io_addr_in == ttc_pkg::ADR_CNT_LO ##1 tick |-> !ma && !mb)
		else $error("compare match after counter write");
	chk_cmp_flag_set: assert property (
		ma |=> r.flg[ttc_pkg::CMPA_BIT])
		else $error("compare a flag not set after match");
	chk_irq_gated: assert property (
		overflow_irq_out |-> $past(r.flg[ttc_pkg::OVF_BIT]) &&
		$past(r.irq_en[ttc_pkg::OVF_BIT]) && $past(global_irq_en_in))
		else $error("overflow irq without enable and flag");
	chk_flag_w1c: assert property (
		s_flg_clr |=> !r.flg[ttc_pkg::OVF_BIT])
		else $error("overflow flag not cleared by write of one");
endmodule

// ===== ttc_cpu_model.sv
`timescale 1ns/1ps
module ttc_cpu_model (
	input  wire logic       clk_sys_in,
	input  wire logic [7:0] rdata_in,
	output logic      [3:0] addr_out,
	output logic      [7:0] wdata_out,
	output logic            we_out,
	output logic            re_out
);
	initial begin
		addr_out = 4'h3;
		wdata_out = 8'h00;
		we_out = 1'b0;
		re_out = 1'b0;
	end
	// one access: strobe for one cycle, data taken after the edge
	task automatic acc(input logic w, input logic [3:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge clk_sys_in);
		addr_out = a;
		wdata_out = d;
		if (a == ttc_pkg::ADR_CTRL_B)
			wdata_out = d & ttc_pkg::CTRL_B_WMASK;
		we_out = w;
		re_out = !w;
		@(negedge clk_sys_in);
		q = rdata_in;
		we_out = 1'b0;
		re_out = 1'b0;
		// released lines show the inverse of the last value
		addr_out = ~a;
		wdata_out = ~wdata_out;
	endtask
	// force bits are only ever written outside pwm modes
	task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
		logic [7:0] q;
		acc(1'b1, lo + 4'h1, v[15:8], q);
		acc(1'b1, lo, v[7:0], q);
	endtask
	task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
		acc(1'b0, lo, 8'h00, v[7:0]);
		acc(1'b0, lo + 4'h1, 8'h00, v[15:8]);
	endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
	logic        clk_sys_in = 1'b0;
	logic        reset_in   = 1'b1;
	logic [3:0]  addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        we;
	logic        re;
	logic        gie        = 1'b1;
	logic [3:0]  vec_ack    = 4'h0;
	logic        cap_pin    = 1'b0;
	logic        cmp        = 1'b0;
	logic        use_cmp    = 1'b0;
	logic        ext_pin    = 1'b0;
	logic [3:0]  irq;
	logic        pa;
	logic        pb;
	logic        ea;
	logic        eb;
	logic [15:0] v0;
	logic [15:0] v1;
	int          n_fail     = 0;
	int          n_checks   = 0;
	int          cycles     = 0;
	int          sh[6]      = '{16, 0, 3, 6, 8, 10};
	always #4 clk_sys_in = ~clk_sys_in;
	ttc_cpu_model u_cpu (.clk_sys_in(clk_sys_in), .rdata_in(rdata),
		.addr_out(addr), .wdata_out(wdata), .we_out(we), .re_out(re));
	ttc_timer16 u_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.io_addr_in(addr), .io_wdata_in(wdata), .io_we_in(we),
		.io_re_in(re), .io_rdata_out(rdata), .global_irq_en_in(gie),
		.vec_ack_in(vec_ack), .capture_input_pin_in(cap_pin),
		.comparator_in(cmp), .capture_from_comparator_in(use_cmp),
		.external_count_pin_in(ext_pin), .capture_irq_out(irq[3]),
		.compare_b_irq_out(irq[2]), .compare_a_irq_out(irq[1]),
		.overflow_irq_out(irq[0]), .compare_output_pin_a_out(pa),
		.compare_output_en_a_out(ea), .compare_output_pin_b_out(pb),
		.compare_output_en_b_out(eb));
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			summarize();
		end
	end
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic w8(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		u_cpu.acc(1'b1, a, d, q);
	endtask
	task automatic rc8(input string nm, input logic [3:0] a,
		input logic [7:0] e);
		logic [7:0] q;
		u_cpu.acc(1'b0, a, 8'h00, q);
		chk(nm, {8'h00, e}, {8'h00, q});
	endtask
	task automatic rc16(input string nm, input logic [3:0] a,
		input logic [15:0] e);
		logic [15:0] q;
		u_cpu.rd16(a, q);
		chk(nm, e, q);
	endtask
	task automatic src(input logic lvl);
		if (use_cmp)
			cmp = lvl;
		else
			cap_pin = lvl;
	endtask
	// set the capture source to lvl, or pulse it for pw cycles
	task automatic cap_edge(input logic [7:0] cb, input logic [15:0] cv,
		input logic lvl, input int pw, input logic hit);
		w8(ttc_pkg::ADR_IRQ_FLG, 8'hFF);
		w8(ttc_pkg::ADR_CTRL_B, cb);
		u_cpu.wr16(ttc_pkg::ADR_CNT_LO, cv);
		u_cpu.wr16(ttc_pkg::ADR_CAP_LO, 16'h0000);
		src(lvl);
		if (pw != 0) begin
			repeat (pw) @(negedge clk_sys_in);
			src(!lvl);
		end
		repeat (24) @(negedge clk_sys_in);
		rc16("capture", ttc_pkg::ADR_CAP_LO, hit ? cv : 16'h0000);
		rc8("cap flag", ttc_pkg::ADR_IRQ_FLG, hit ? 8'h20 : 8'h00);
		if (hit)
			chk("cap irq", 16'h0001, {15'h0000, irq[3]});
	endtask
	logic [3:0] ra[8] = '{ttc_pkg::ADR_CTRL_B, ttc_pkg::ADR_CTRL_C,
		ttc_pkg::ADR_CNT_LO, ttc_pkg::ADR_CNT_HI, ttc_pkg::ADR_CAP_LO,
		ttc_pkg::ADR_CMPA_LO, ttc_pkg::ADR_IRQ_EN, ttc_pkg::ADR_IRQ_FLG};
	initial begin
		repeat (10) @(negedge clk_sys_in);
		reset_in = 1'b0;
		foreach (ra[i])
			rc8("reset value", ra[i], 8'h00);
		w8(ttc_pkg::ADR_CTRL_C, 8'h3F);
		rc8("ctrl c", ttc_pkg::ADR_CTRL_C, 8'h00);
		w8(ttc_pkg::ADR_IRQ_EN, 8'hFF);
		rc8("irq enable", ttc_pkg::ADR_IRQ_EN, 8'h27);
		w8(4'h3, 8'hFF);
		rc8("unmapped", 4'h3, 8'h00);
		w8(ttc_pkg::ADR_CTRL_B, 8'hFF);
		rc8("ctrl b", ttc_pkg::ADR_CTRL_B, 8'hDF);
		u_cpu.wr16(ttc_pkg::ADR_CMPA_LO, 16'h1234);
		rc16("cmp a", ttc_pkg::ADR_CMPA_LO, 16'h1234);
		w8(ttc_pkg::ADR_CMPA_HI, 8'h56);
		w8(ttc_pkg::ADR_CMPB_LO, 8'h78);
		rc16("cmp b", ttc_pkg::ADR_CMPB_LO, 16'h5678);
		rc16("cmp a", ttc_pkg::ADR_CMPA_LO, 16'h1234);
		// read edges 1024 cycles apart for every prescaler code
		for (int i = 0; i < 6; i++) begin
			w8(ttc_pkg::ADR_CTRL_B, 8'(i));
			u_cpu.rd16(ttc_pkg::ADR_CNT_LO, v0);
			repeat (1020) @(negedge clk_sys_in);
			u_cpu.rd16(ttc_pkg::ADR_CNT_LO, v1);
			chk("prescale", 16'(1024 >> sh[i]), v1 - v0);
		end
		for (int c = 6; c < 8; c++) begin
			w8(ttc_pkg::ADR_CTRL_B, 8'(c));
			u_cpu.rd16(ttc_pkg::ADR_CNT_LO, v0);
			repeat (5) begin
				ext_pin = 1'b1;
				repeat (4) @(negedge clk_sys_in);
				ext_pin = 1'b0;
				repeat (4) @(negedge clk_sys_in);
			end
			repeat (10) @(negedge clk_sys_in);
			u_cpu.rd16(ttc_pkg::ADR_CNT_LO, v1);
			chk("ext count", 16'h0005, v1 - v0);
		end
		cap_edge(8'h40, 16'h0101, 1'b1, 0, 1'b1);
		cap_edge(8'h40, 16'h0202, 1'b0, 0, 1'b0);
		cap_edge(8'h00, 16'h0303, 1'b1, 0, 1'b0);
		cap_edge(8'h00, 16'h0404, 1'b0, 0, 1'b1);
		cap_edge(8'hC0, 16'h0505, 1'b1, 3, 1'b0);
		cap_edge(8'hC0, 16'h0606, 1'b1, 0, 1'b1);
		cap_edge(8'h18, 16'h0707, 1'b0, 0, 1'b0);
		use_cmp = 1'b1;
		cap_edge(8'h40, 16'h0808, 1'b1, 0, 1'b1);
		use_cmp = 1'b0;
		w8(ttc_pkg::ADR_IRQ_FLG, 8'hFF);
		u_cpu.wr16(ttc_pkg::ADR_CMPA_LO, 16'h0012);
		u_cpu.wr16(ttc_pkg::ADR_CMPB_LO, 16'h0014);
		u_cpu.wr16(ttc_pkg::ADR_CNT_LO, 16'hFFF8);
		w8(ttc_pkg::ADR_CTRL_B, 8'h01);
		repeat (30) @(negedge clk_sys_in);
		w8(ttc_pkg::ADR_CTRL_B, 8'h00);
		rc8("flags", ttc_pkg::ADR_IRQ_FLG, 8'h07);
		chk("irqs", 16'h0007, {12'h000, irq});
		vec_ack = 4'h2;
		@(negedge clk_sys_in);
		vec_ack = 4'h0;
		rc8("flags", ttc_pkg::ADR_IRQ_FLG, 8'h05);
		chk("irqs", 16'h0005, {12'h000, irq});
		w8(ttc_pkg::ADR_IRQ_FLG, 8'h01);
		rc8("flags", ttc_pkg::ADR_IRQ_FLG, 8'h04);
		gie = 1'b0;
		repeat (2) @(negedge clk_sys_in);
		chk("irqs", 16'h0000, {12'h000, irq});
		w8(ttc_pkg::ADR_IRQ_FLG, 8'hFF);
		u_cpu.wr16(ttc_pkg::ADR_CMPA_LO, 16'h0040);
		w8(ttc_pkg::ADR_CTRL_B, 8'h01);
		u_cpu.wr16(ttc_pkg::ADR_CNT_LO, 16'h0040);
		repeat (8) @(negedge clk_sys_in);
		w8(ttc_pkg::ADR_CTRL_B, 8'h00);
		rc8("no match", ttc_pkg::ADR_IRQ_FLG, 8'h00);
		w8(ttc_pkg::ADR_CTRL_A, 8'h50);
		w8(ttc_pkg::ADR_CTRL_B, 8'h08);
		u_cpu.wr16(ttc_pkg::ADR_CNT_LO, 16'h0007);
		w8(ttc_pkg::ADR_IRQ_FLG, 8'hFF);
		v0 = {14'h0000, pa, pb};
		w8(ttc_pkg::ADR_CTRL_C, 8'hC0);
		chk("forced pins", ~v0 & 16'h0003, {14'h0000, pa, pb});
		chk("pin enables", 16'h0003, {14'h0000, ea, eb});
		rc8("ctrl c", ttc_pkg::ADR_CTRL_C, 8'h00);
		rc8("forced flags", ttc_pkg::ADR_IRQ_FLG, 8'h00);
		rc16("counter", ttc_pkg::ADR_CNT_LO, 16'h0007);
		summarize();
	end
endmodule
